// >>> rles_chk.sv
// Purpose: port checker for rles_top
// Assumes: bound to every rles_top instance
// Notes: reference input is taken as quiet when low for 40 cycles
`timescale 1ns/1ps
`default_nettype none
`include "rles_consts.svh"
module rles_chk
    import rles_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`RLES_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire rles_lane_ev_s lane_ev,
    input wire rles_link_ev_s link_ev,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic sysref_pin,
    input wire logic irq,
    input wire logic link_reinit_pulse,
    input wire logic lemc_boundary
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [5:0] gap_q;
    logic [5:0] quiet_q;
    wire logic rd_log = reg_rd && reg_addr == `RLES_OFF_ERR;
    wire logic wr_reinit = reg_wr && reg_addr == `RLES_OFF_CTRL && reg_wdata[0];
    // Cycles since last boundary and since reference was last high, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 6'h00;
            quiet_q <= 6'h00;
        end else begin
            gap_q <= lemc_boundary ? 6'h00 : gap_q + 6'(gap_q != 6'h3f);
            quiet_q <= sysref_pin ? 6'h00 : quiet_q + 6'(quiet_q != 6'h3f);
        end
    end
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_pulse_one;
        link_reinit_pulse |=> !link_reinit_pulse;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("reinit pulse too long");
    property p_pulse_cause;
        link_reinit_pulse |-> $past(wr_reinit, 2);
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("reinit without request");
    property p_irq_hold;
        irq && !reg_wr && !$past(reg_wr) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped uncleared");
    property p_gb;
        (|lane_ev.gb_over) ##1 rd_log |=> reg_rdata[`RLES_B_GB_OVER];
    endproperty
    a_gb: assert property (p_gb) else $error("gearbox flag missing");
    property p_ecc;
        link_ev.ecc_double ##1 rd_log |=> reg_rdata[`RLES_B_ECC_FATAL];
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc flag missing");
    property p_frame;
        frame_valid && !frame_ready ##1 rd_log |=> reg_rdata[`RLES_B_FRAME_RDY];
    endproperty
    a_frame: assert property (p_frame) else $error("frame ready flag missing");
    property p_lemc;
        lemc_boundary && quiet_q >= 6'd40 |-> gap_q == 6'd31;
    endproperty
    a_lemc: assert property (p_lemc) else $error("boundary period wrong");
endmodule // rles_chk
bind rles_top rles_chk u_rles_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .lane_ev, .link_ev, .frame_valid, .frame_ready, .sysref_pin, .irq,
    .link_reinit_pulse, .lemc_boundary);
`default_nettype wire

// >>> rles_consts.svh
// Purpose: constants for the receive link error status block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: offsets not fixed by the map are local choices
//
// Overview of operation
// - With continuous detect on, each reference rising edge resets the local multiblock counter.
// - Writing 1 to reinit restarts the receive link, keeping reference detection info.
// - Reinit bit resets to 0, self-clears on entry; writing 0 does nothing.
// - A log bit raises the interrupt only when its enable bit is 1.
// - Log bit 22 sets on uncorrectable double-bit ECC error; write 1 clears.
// - Log bit 21 sets on corrected single-bit ECC error.
// - Log bit 20 sets on any lane elastic buffer overflow.
// - Log bit 19 sets on any lane multiblock alignment lock loss.
// - Log bit 18 sets on any lane sync header lock loss.
// - Log bit 17 sets on gearbox overflow, bit 16 on underflow.
// - Log bit 14 sets on CRC parity mismatch.
// - Log bit 11 sets on command channel parity mismatch.
// - Log bit 10 sets on unexpected end-of-extended-multiblock identifier.
// - Log bit 9 sets when pilot pattern misses its expected position.
// - Log bit 8 sets on sync header 11 or 00.
// - Log bit 7 sets when lane skew exceeds one multiblock boundary.
// - Log bit 4 sets on any lane CDR lock loss while running.
// - With the command channel used, bit 3 sets when command ready drops while a command is valid.
// - Bit 2 sets when frame data ready is 0 while data valid.
// - With continuous detect on, bit 0 sets on reference period mismatch.
`ifndef RLES_CONSTS_SVH
`define RLES_CONSTS_SVH

`define RLES_ADDR_W 8
`define RLES_OFF_CTRL 8'h54
`define RLES_OFF_ERR 8'h60
`define RLES_OFF_EN 8'h64
`define RLES_OFF_STAT 8'h68

`define RLES_CTRL_REINIT 0
`define RLES_CTRL_ALWAYSON 1
`define RLES_CTRL_RESET 32'h0000_0000

`define RLES_ERR_MASK 32'h007f_4fff
`define RLES_EN_RESET 32'h005f_4ff1

`define RLES_B_ECC_FATAL 22
`define RLES_B_ECC_CORR 21
`define RLES_B_EB_FULL 20
`define RLES_B_EMB_UNLOCK 19
`define RLES_B_HEADER_LOCK_LOST 18
`define RLES_B_GB_OVER 17
`define RLES_B_GB_UNDER 16
`define RLES_B_CRC 14
`define RLES_B_CMD_PAR 11
`define RLES_B_EOEMB 10
`define RLES_B_EOMB 9
`define RLES_B_SYNC_HDR 8
`define RLES_B_DESKEW 7
`define RLES_B_PC_EMPTY 6
`define RLES_B_PC_FULL 5
`define RLES_B_CDR 4
`define RLES_B_CMD_RDY 3
`define RLES_B_FRAME_RDY 2
`define RLES_B_LINK_RDY 1
`define RLES_B_SYSREF 0

`define RLES_LANES 8
`define RLES_LEMC_W 16
`define RLES_LEMC_PERIOD 16'd32

`endif

// >>> rles_pkg.sv
// Purpose: types for the receive link error status block
// Assumes: constants come from rles_consts.svh
// Notes: none
`include "rles_consts.svh"
package rles_pkg;
    typedef logic [`RLES_LANES-1:0] rles_lanes_t;

    // Per-lane event pulses from the lane datapath
    typedef struct packed {
        rles_lanes_t eb_overflow;
        rles_lanes_t emb_lock_lost;
        rles_lanes_t header_lock_lost;
        rles_lanes_t gb_over;
        rles_lanes_t gb_under;
        rles_lanes_t pc_empty;
        rles_lanes_t pc_full;
        rles_lanes_t cdr_lock_lost;
    } rles_lane_ev_s;

    // Link-wide event pulses
    typedef struct packed {
        logic ecc_double;
        logic ecc_single;
        logic crc_mismatch;
        logic cmd_parity;
        logic eoemb_bad;
        logic pilot_misplaced;
        logic sync_hdr_bad;
        logic deskew_over;
        logic link_data_rdy_err;
    } rles_link_ev_s;

    typedef enum logic [1:0] {
        RLES_IDLE,
        RLES_REINIT,
        RLES_RUN
    } rles_state_e;
endpackage

// >>> rles_top.sv
// Purpose: receive link error log, interrupt and reinit control
// Assumes: all event inputs are synchronous to clk
// Notes: reference input comes from a pin and is synchronised
`timescale 1ns/1ps
`default_nettype none
`include "rles_consts.svh"
module rles_top
    import rles_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`RLES_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire rles_lane_ev_s lane_ev,
    input wire rles_link_ev_s link_ev,
    input wire logic link_running,
    input wire logic cmd_channel_used,
    input wire logic command_valid_out,
    input wire logic command_ready_in,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic sysref_pin,
    output logic irq,
    output logic link_reinit_pulse,
    output logic lemc_boundary
);

    ////////////////////////////////////////////////////////////////////////
    // Register decode

    logic [31:0] err_q;
    logic [31:0] err_d;
    logic [31:0] en_q;
    logic alwayson_q;
    logic reinit_req_q;
    logic [31:0] rdata_d;
    logic [31:0] set_vec;
    rles_state_e state_q;
    rles_state_e state_d;

    wire hit_ctrl = reg_addr == `RLES_OFF_CTRL;
    wire hit_err = reg_addr == `RLES_OFF_ERR;
    wire hit_en = reg_addr == `RLES_OFF_EN;
    wire hit_stat = reg_addr == `RLES_OFF_STAT;
    wire wr_ctrl = reg_wr && hit_ctrl;
    wire wr_err = reg_wr && hit_err;
    wire wr_en = reg_wr && hit_en;
    wire reinit_set = wr_ctrl && reg_wdata[`RLES_CTRL_REINIT];
    wire [31:0] w1c_vec = wr_err ? (reg_wdata & `RLES_ERR_MASK) : 32'h0000_0000;

    wire [31:0] ctrl_view = {30'h0000_0000, alwayson_q, reinit_req_q};
    wire [31:0] stat_view = {30'h0000_0000, state_q == RLES_RUN, irq};

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_d = ctrl_view;
        end else if (hit_err) begin
            rdata_d = err_q;
        end else if (hit_en) begin
            rdata_d = en_q;
        end else if (hit_stat) begin
            rdata_d = stat_view;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_q <= `RLES_EN_RESET;
            alwayson_q <= 1'b0;
        end else begin
            if (wr_en) begin
                en_q <= reg_wdata & `RLES_ERR_MASK;
            end
            if (wr_ctrl) begin
                alwayson_q <= reg_wdata[`RLES_CTRL_ALWAYSON];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link reinit sequencing

    // Request bit is write-1-to-set; writing 0 leaves it alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reinit_req_q <= 1'b0;
        end else if (reinit_set) begin
            reinit_req_q <= 1'b1;
        end else if (state_q == RLES_REINIT) begin
            reinit_req_q <= 1'b0;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            RLES_IDLE: state_d = RLES_RUN;
            RLES_RUN: begin
                if (reinit_req_q) begin
                    state_d = RLES_REINIT;
                end
            end
            RLES_REINIT: state_d = RLES_RUN;
            default: state_d = RLES_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= RLES_IDLE;
            link_reinit_pulse <= 1'b0;
        end else begin
            state_q <= state_d;
            link_reinit_pulse <= state_d == RLES_REINIT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference edge and local multiblock counter

    logic sref_m_q;
    logic sref_s_q;
    logic sref_prev_q;
    logic [`RLES_LEMC_W-1:0] lemc_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sref_m_q <= 1'b0;
            sref_s_q <= 1'b0;
            sref_prev_q <= 1'b0;
        end else begin
            sref_m_q <= sysref_pin;
            sref_s_q <= sref_m_q;
            sref_prev_q <= sref_s_q;
        end
    end

    wire sref_rise = sref_s_q && !sref_prev_q;
    wire sref_realign = alwayson_q && sref_rise;
    wire lemc_wrap = lemc_q == `RLES_LEMC_PERIOD - 16'd1;
    // A rising edge away from a boundary means the period is not a multiple
    wire sref_mismatch = sref_realign && !lemc_wrap;

    // Counter lives outside link reinit so the reference alignment survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lemc_q <= '0;
            lemc_boundary <= 1'b0;
        end else begin
            if (sref_realign || lemc_wrap) begin
                lemc_q <= '0;
            end else begin
                lemc_q <= lemc_q + 16'd1;
            end
            lemc_boundary <= sref_realign || lemc_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error event collection

    wire run = link_running;
    wire cmd_rdy_err = cmd_channel_used && command_valid_out && !command_ready_in;
    wire frame_rdy_err = frame_valid && !frame_ready;

    always_comb begin
        set_vec = 32'h0000_0000;
        set_vec[`RLES_B_ECC_FATAL] = link_ev.ecc_double;
        set_vec[`RLES_B_ECC_CORR] = link_ev.ecc_single;
        set_vec[`RLES_B_EB_FULL] = |lane_ev.eb_overflow;
        set_vec[`RLES_B_EMB_UNLOCK] = |lane_ev.emb_lock_lost;
        set_vec[`RLES_B_HEADER_LOCK_LOST] = |lane_ev.header_lock_lost;
        set_vec[`RLES_B_GB_OVER] = |lane_ev.gb_over;
        set_vec[`RLES_B_GB_UNDER] = |lane_ev.gb_under;
        set_vec[`RLES_B_CRC] = link_ev.crc_mismatch;
        set_vec[`RLES_B_CMD_PAR] = link_ev.cmd_parity;
        set_vec[`RLES_B_EOEMB] = link_ev.eoemb_bad;
        set_vec[`RLES_B_EOMB] = link_ev.pilot_misplaced;
        set_vec[`RLES_B_SYNC_HDR] = link_ev.sync_hdr_bad;
        set_vec[`RLES_B_DESKEW] = link_ev.deskew_over;
        set_vec[`RLES_B_PC_EMPTY] = run && |lane_ev.pc_empty;
        set_vec[`RLES_B_PC_FULL] = run && |lane_ev.pc_full;
        set_vec[`RLES_B_CDR] = run && |lane_ev.cdr_lock_lost;
        set_vec[`RLES_B_CMD_RDY] = cmd_rdy_err;
        set_vec[`RLES_B_FRAME_RDY] = frame_rdy_err;
        set_vec[`RLES_B_LINK_RDY] = link_ev.link_data_rdy_err;
        set_vec[`RLES_B_SYSREF] = sref_mismatch;
    end

    // New events win over a simultaneous write-1-to-clear
    assign err_d = ((err_q & ~w1c_vec) | set_vec) & `RLES_ERR_MASK;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            err_q <= err_d;
            irq <= |(err_d & en_q);
        end
    end

    wire unused_ok = run;

endmodule // rles_top
`default_nettype wire

// >>> rles_top_tb.sv
// Purpose: self-checking bench for rles_top
// Assumes: reference pin pulsed only by the period scenario
// Notes: each scenario is one task
`timescale 1ns/1ps
`default_nettype none
`include "rles_consts.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module rles_top_tb
    import rles_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
    logic link_running = 1'b1, cmd_channel_used = 1'b0, command_valid_out = 1'b0;
    logic frame_valid = 1'b0, command_ready_in, frame_ready, irq, link_reinit_pulse;
    logic lemc_boundary, sysref_pin = 1'b0;
    logic [`RLES_ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    rles_lane_ev_s lane_ev = '0;
    rles_link_ev_s link_ev = '0;
    int mismatches = 0, n_compared = 0, cyc = 0, n_pulse = 0;
    rles_top u_rles_top (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .lane_ev, .link_ev, .link_running, .cmd_channel_used, .command_valid_out,
        .command_ready_in, .frame_valid, .frame_ready, .sysref_pin, .irq,
        .link_reinit_pulse, .lemc_boundary);
    rles_upstream u_rles_upstream (.stall, .command_ready_in, .frame_ready);
    always #5 clk = ~clk;
    always @(posedge clk) if (link_reinit_pulse === 1'b1) n_pulse++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            mismatches++;
            end_sim();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read also ends any one-cycle event set up just before it
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        lane_ev <= '0;
        link_ev <= '0;
        frame_valid <= 1'b0;
        command_valid_out <= 1'b0;
        stall <= 1'b0;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] v;
        rd(a, v);
        `CHK(n, e, v)
    endtask
    task automatic t_reset();
        rchk(8'h60, 32'h0, "log");
        rchk(8'h64, 32'h005f_4ff1, "enable");
        rchk(8'h54, 32'h0, "control");
        rchk(8'h68, 32'h2, "status");
        rchk(8'h70, 32'h0, "unmapped");
    endtask
    task automatic t_events();
        int lb[17] = '{20, 19, 18, 17, 16, 6, 5, 4, 22, 21, 14, 11, 10, 9, 8, 7, 1};
        logic [31:0] en = 32'h005f_4ff1;
        logic [31:0] v;
        for (int k = 0; k < 17; k++) begin
            @(posedge clk);
            if (k < 8) lane_ev[63 - 9 * k] <= 1'b1;
            else link_ev[16 - k] <= 1'b1;
            rd(8'h60, v);
            `CHK("log bit", 32'h1 << lb[k], v)
            `CHK("irq", en[lb[k]], irq)
            wr(8'h60, 32'hffff_ffff);
        end
        rchk(8'h60, 32'h0, "log cleared");
        // Link reset after the phase FIFO events, as the system must do
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(8'h64, 32'h005f_4ff1, "enable after reset");
    endtask
    task automatic t_idle_link();
        @(posedge clk);
        link_running <= 1'b0;
        lane_ev.pc_empty <= 8'hff;
        lane_ev.pc_full <= 8'hff;
        lane_ev.cdr_lock_lost <= 8'hff;
        rchk(8'h60, 32'h0, "idle log");
        link_running <= 1'b1;
    endtask
    task automatic t_ready();
        @(posedge clk);
        cmd_channel_used <= 1'b1;
        command_valid_out <= 1'b1;
        frame_valid <= 1'b1;
        stall <= 1'b1;
        rchk(8'h60, 32'hc, "ready log");
        `CHK("irq off", 1'b0, irq)
        wr(8'h64, 32'h4);
        repeat (2) @(posedge clk);
        `CHK("irq on", 1'b1, irq)
        wr(8'h60, 32'hc);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        wr(8'h64, 32'h005f_4ff1);
        @(posedge clk);
        command_valid_out <= 1'b1;
        frame_valid <= 1'b1;
        rchk(8'h60, 32'h0, "ready kept");
    endtask
    task automatic t_reinit();
        wr(8'h54, 32'h1);
        repeat (4) @(posedge clk);
        `CHK("pulses", 1, n_pulse)
        rchk(8'h54, 32'h0, "reinit bit");
        wr(8'h54, 32'h0);
        repeat (4) @(posedge clk);
        `CHK("pulses", 1, n_pulse)
    endtask
    // Second rise 32 cycles after the first lands on a wrap, third one off it
    task automatic t_sysref();
        wr(8'h54, 32'h0);
        wr(8'h54, 32'h2);
        @(posedge clk);
        sysref_pin <= 1'b1;
        @(posedge clk);
        sysref_pin <= 1'b0;
        repeat (10) @(posedge clk);
        wr(8'h60, 32'h1);
        repeat (19) @(posedge clk);
        sysref_pin <= 1'b1;
        @(posedge clk);
        sysref_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rchk(8'h60, 32'h0, "period match");
        @(posedge clk);
        sysref_pin <= 1'b1;
        @(posedge clk);
        sysref_pin <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("boundary", 1'b1, lemc_boundary)
        rchk(8'h60, 32'h1, "period off");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_events();
        t_idle_link();
        t_ready();
        t_reinit();
        t_sysref();
        end_sim();
    end
endmodule // rles_top_tb
`default_nettype wire

// >>> rles_upstream.sv
// Purpose: upstream ready model
// Assumes: upstream is always ready unless told to stall
// Notes: stall drops both readies at once
`timescale 1ns/1ps
`default_nettype none
module rles_upstream (
    input wire logic stall,
    output logic command_ready_in,
    output logic frame_ready
);
    assign command_ready_in = !stall;
    assign frame_ready = !stall;
endmodule // rles_upstream
`default_nettype wire
